/* File: design/timer_a_map.vh */
`ifndef TIMER_A_MAP_VH
`define TIMER_A_MAP_VH

// byte offsets
`define OFS_CTLA      6'h00
`define OFS_CTLB      6'h01
`define OFS_CTRLC     6'h02
`define OFS_CTLD      6'h03
`define OFS_CTRLECLR  6'h04
`define OFS_CTLESET   6'h05
`define OFS_CTRLFCLR  6'h06
`define OFS_CTRLFSET  6'h07
`define OFS_FLAGS     6'h0B
`define OFS_COUNT     6'h20
`define OFS_PER       6'h26
`define OFS_CV0       6'h28
`define OFS_PERBUF    6'h36
`define OFS_CVBUF0    6'h38

// field positions
`define CTLA_EN       0
`define CTRLE_DIR     0
`define CTRLE_LOCK    1
`define CTRLE_CMD_LO  2
`define CTLB_CHEN0    4
`define FLG_WRAP      0
`define FLG_HIUF      1
`define FLG_CV0       4

// commands
`define CMD_NONE      2'h0
`define CMD_UPDATE    2'h1
`define CMD_RESTART   2'h2
`define CMD_RESET     2'h3

// waveform modes
`define WG_NORMAL     3'h0
`define WG_FREQ       3'h1
`define WG_SS         3'h3
`define WG_DSTOP      3'h5
`define WG_DSBOTH     3'h6
`define WG_DSBOTTOM   3'h7

// channel kinds
`define KIND_NONE     2'h0
`define KIND_FREQ     2'h1
`define KIND_SS       2'h2
`define KIND_DS       2'h3

// reset values
`define RST_BYTE      8'h00
`define RST_WORD      16'h0000
`define RST_PER       16'hFFFF
`endif

/* File: design/prescale_tick.v */
`timescale 1ns/10ps
`include "timer_a_map.vh"

module prescale_tick (
    input wire core_clk,
    input wire nrst,
    input wire run,
    input wire [2:0] prescale_select,
    output wire tick
);

reg [9:0] div_r;
wire [9:0] mask;

// divisors 1,2,4,8,16,64,256,1024
function [9:0] div_mask;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: div_mask = 10'h000;
            3'h1: div_mask = 10'h001;
            3'h2: div_mask = 10'h003;
            3'h3: div_mask = 10'h007;
            3'h4: div_mask = 10'h00F;
            3'h5: div_mask = 10'h03F;
            3'h6: div_mask = 10'h0FF;
            default: div_mask = 10'h3FF;
        endcase
    end
endfunction

assign mask = div_mask(prescale_select);
assign tick = run & ((div_r & mask) == mask);

always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        div_r <= 10'h000;
    end else if (run) begin
        div_r <= div_r + 10'h001;
    end else begin
        div_r <= 10'h000;
    end
end

endmodule

/* File: design/wave_channel.v */
`timescale 1ns/10ps
`include "timer_a_map.vh"

module wave_channel (
    input wire core_clk,
    input wire nrst,
    input wire step,
    input wire [1:0] kind,
    input wire bottom,
    input wire up,
    input wire match,
    input wire cmp_zero,
    input wire cmp_top,
    input wire clear,
    output reg level_r
);

always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        level_r <= 1'b0;
    end else if (clear) begin
        level_r <= 1'b0; // [RULE14]
    end else if (step) begin
        case (kind)
            `KIND_FREQ: begin
                if (match) begin
                    level_r <= ~level_r; // [RULE1] [RULE2]
                end
            end
            `KIND_SS: begin
                // compare above top never matches, so the level stays high
                if (bottom) begin
                    level_r <= ~cmp_zero; // [RULE3] [RULE4]
                end else if (match) begin
                    level_r <= 1'b0; // [RULE3]
                end
            end
            `KIND_DS: begin
                if (bottom) begin
                    level_r <= ~cmp_zero; // [RULE7] [RULE8]
                end else if (match) begin
                    level_r <= up ? cmp_top : 1'b1; // [RULE7] [RULE8]
                end
            end
            default: level_r <= level_r;
        endcase
    end
end

endmodule

/* File: design/timer_waveform_split_mode.v */
`timescale 1ns/10ps
`include "timer_a_map.vh"

// Functional notes
// (RULE1) frequency mode toggles every compare0 plus one ticks
// (RULE2) frequency top is compare0; channels toggle on match
// (RULE3) sawtooth: up to period, high at zero, low on match
// (RULE4) sawtooth: compare zero low, above top high
// (RULE5) software never selects sawtooth with down counting
// (RULE6) sawtooth period lasts period value plus one
// (RULE7) dual slope: up then down, clear up, set down
// (RULE8) dual slope: compare zero low, top high
// (RULE9) dual slope period is twice period value
// (RULE10) pin override needs enable bit and waveform mode
// (RULE11) command field in control E set acts immediately
// (RULE12) update command ignores lock update
// (RULE13) update copies valid buffers unless locked
// (RULE14) restart clears count, direction and outputs
// (RULE15) reset command restores registers, only while disabled
// (RULE16) split: two 8-bit down counters, three channels each
// (RULE17) split: no buffers, byte access everywhere
// (RULE18) split: high timer raises only underflow flag
// (RULE19) mode change keeps register values
// (RULE20) split start: split bit, periods, then enable
// (RULE21) events are one clock pulses
// (RULE22) high underflow event exists only in split
// (RULE23) events fire exactly with their flags
// (RULE24) split counters reload from own period byte
module timer_waveform_split_mode #(
    parameter AW = 6,
    parameter NCH = 3
) (
    input wire core_clk,
    input wire nrst,
    input wire [AW-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata_r,
    input wire [2*NCH-1:0] pin_invert,
    output reg [2*NCH-1:0] pin_override_r,
    output reg [2*NCH-1:0] waveform_out_n_r,
    output reg overflow_event_r,
    output reg high_byte_underflow_r,
    output reg [NCH-1:0] compare_event_r
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg en_r;
reg [2:0] prescale_select_r;
reg [7:0] control_b_reg_r;
reg [7:0] ctrlc_r;
reg dual_8bit_enable_r;
reg dir_r;
reg lock_update_r;
reg [NCH:0] bv_r;
reg [7:0] interrupt_flag_reg_r;
reg [15:0] count_value_r;
reg [15:0] per_r;
reg [15:0] perbuf_r;
reg [15:0] compare_value_r [0:NCH-1];
reg [15:0] compare_buffer_r [0:NCH-1];
reg [7:0] rd_nxt;
integer j;
integer m;
integer n;

wire tick;
wire wr_e_set = wr_stb & (addr == `OFS_CTLESET);
wire [1:0] cmd = wdata[`CTRLE_CMD_LO+1:`CTRLE_CMD_LO];
wire cmd_upd = wr_e_set & (cmd == `CMD_UPDATE); // [RULE11]
wire cmd_restart = wr_e_set & (cmd == `CMD_RESTART);
wire cmd_reset = wr_e_set & (cmd == `CMD_RESET) & ~en_r; // [RULE15]
wire split = dual_8bit_enable_r;
wire [2:0] waveform_mode_select = control_b_reg_r[2:0];

prescale_tick u_pre (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(en_r),
    .prescale_select(prescale_select_r),
    .tick(tick)
);

////////////////////////////////////////////////////////////////////////////////
// count sequencing
wire step = tick & ~cmd_restart;
wire frequency_mode = ~split & (waveform_mode_select == `WG_FREQ);
wire sawtooth_mode = ~split & (waveform_mode_select == `WG_SS);
wire ds_mode = ~split & (waveform_mode_select >= `WG_DSTOP);
wire [15:0] top = frequency_mode ? compare_value_r[0] : per_r; // [RULE2]
wire at_top = ~dir_r & (count_value_r >= top);
wire at_bot = dir_r & (count_value_r == 16'h0000);
wire n_bottom = ds_mode ? at_bot : (at_top | at_bot);
wire [7:0] low_byte_count = count_value_r[7:0];
wire [7:0] high_byte_count = count_value_r[15:8];
wire low_byte_underflow = split & (low_byte_count == 8'h00);
wire high_byte_underflow = split & (high_byte_count == 8'h00);
reg upd_pt;

always @* begin
    case (waveform_mode_select)
        `WG_DSTOP: upd_pt = at_top;
        `WG_DSBOTH: upd_pt = at_top | at_bot;
        `WG_DSBOTTOM: upd_pt = at_bot;
        default: upd_pt = n_bottom;
    endcase
end

wire wrap_cond = step & (split ? low_byte_underflow : upd_pt);
wire hiuf_cond = step & high_byte_underflow; // [RULE18] [RULE22]
wire do_update = ~split & (cmd_upd | (step & upd_pt & ~lock_update_r)); // [RULE12] [RULE13]

////////////////////////////////////////////////////////////////////////////////
// channels
wire [NCH-1:0] lo_level;
wire [NCH-1:0] hi_level;
wire [NCH-1:0] lo_match;
wire [1:0] lo_kind = split ? `KIND_SS :
                     frequency_mode ? `KIND_FREQ :
                     sawtooth_mode ? `KIND_SS :
                     ds_mode ? `KIND_DS : `KIND_NONE;

genvar k;
generate
    for (k = 0; k < NCH; k = k + 1) begin : g_ch
        wire [15:0] cv = compare_value_r[k];
        assign lo_match[k] = split ? (low_byte_count == cv[7:0]) : (count_value_r == cv);
        wave_channel u_lo (
            .core_clk(core_clk),
            .nrst(nrst),
            .step(step),
            .kind(lo_kind),
            .bottom(split ? low_byte_underflow : n_bottom),
            .up(~dir_r),
            .match(lo_match[k]),
            .cmp_zero(split ? (cv[7:0] == 8'h00) : (cv == 16'h0000)),
            .cmp_top(cv == top),
            .clear(cmd_restart | cmd_reset),
            .level_r(lo_level[k])
        );
        wave_channel u_hi (
            .core_clk(core_clk),
            .nrst(nrst),
            .step(step),
            .kind(split ? `KIND_SS : `KIND_NONE), // [RULE16]
            .bottom(high_byte_underflow),
            .up(1'b0),
            .match(high_byte_count == cv[15:8]),
            .cmp_zero(cv[15:8] == 8'h00),
            .cmp_top(1'b0),
            .clear(cmd_restart | cmd_reset),
            .level_r(hi_level[k])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// state and register writes
task clear_all;
    begin
        en_r <= 1'b0;
        prescale_select_r <= 3'h0;
        control_b_reg_r <= `RST_BYTE;
        ctrlc_r <= `RST_BYTE;
        dual_8bit_enable_r <= 1'b0;
        dir_r <= 1'b0;
        lock_update_r <= 1'b0;
        bv_r <= {(NCH+1){1'b0}};
        interrupt_flag_reg_r <= `RST_BYTE;
        count_value_r <= `RST_WORD;
        per_r <= `RST_PER;
        perbuf_r <= `RST_PER;
        for (j = 0; j < NCH; j = j + 1) begin
            compare_value_r[j] <= `RST_WORD;
            compare_buffer_r[j] <= `RST_WORD;
        end
    end
endtask

always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        clear_all;
    end else if (cmd_reset) begin
        clear_all; // [RULE15]
    end else begin
        // counting; a bus write to the count below takes priority
        if (cmd_restart) begin
            count_value_r <= `RST_WORD; // [RULE14]
            dir_r <= 1'b0;
        end else if (step) begin
            if (split) begin
                count_value_r[7:0] <= low_byte_underflow ? per_r[7:0] :
                    low_byte_count - 8'h01; // [RULE16] [RULE24]
                count_value_r[15:8] <= high_byte_underflow ? per_r[15:8] :
                    high_byte_count - 8'h01; // [RULE24]
            end else if (ds_mode) begin
                if (at_top) begin
                    dir_r <= 1'b1; // [RULE7] [RULE9]
                    count_value_r <= count_value_r - 16'h0001;
                end else if (at_bot) begin
                    dir_r <= 1'b0;
                    count_value_r <= 16'h0001;
                end else begin
                    count_value_r <= dir_r ? count_value_r - 16'h0001 :
                        count_value_r + 16'h0001;
                end
            end else if (at_top) begin
                count_value_r <= 16'h0000; // [RULE3] [RULE6] [RULE1]
            end else if (at_bot) begin
                count_value_r <= top;
            end else begin
                count_value_r <= dir_r ? count_value_r - 16'h0001 :
                    count_value_r + 16'h0001;
            end
        end
        if (do_update) begin
            if (bv_r[0]) begin
                per_r <= perbuf_r; // [RULE13]
            end
            for (j = 0; j < NCH; j = j + 1) begin
                if (bv_r[j+1]) begin
                    compare_value_r[j] <= compare_buffer_r[j];
                end
            end
            bv_r <= {(NCH+1){1'b0}};
        end
        // every register is a plain byte, which also covers split access
        if (wr_stb) begin // [RULE17] [RULE19]
            case (addr)
                `OFS_CTLA: begin
                    en_r <= wdata[`CTLA_EN];
                    prescale_select_r <= wdata[3:1];
                end
                `OFS_CTLB: control_b_reg_r <= wdata;
                `OFS_CTRLC: ctrlc_r <= wdata;
                `OFS_CTLD: dual_8bit_enable_r <= wdata[0];
                `OFS_CTRLECLR: begin
                    if (wdata[`CTRLE_DIR]) dir_r <= 1'b0;
                    if (wdata[`CTRLE_LOCK]) lock_update_r <= 1'b0;
                end
                `OFS_CTLESET: begin
                    if (wdata[`CTRLE_DIR] & ~cmd_restart) dir_r <= 1'b1;
                    if (wdata[`CTRLE_LOCK]) lock_update_r <= 1'b1;
                end
                `OFS_CTRLFCLR: bv_r <= bv_r & ~wdata[NCH:0];
                `OFS_CTRLFSET: bv_r <= bv_r | wdata[NCH:0];
                `OFS_COUNT: count_value_r[7:0] <= wdata;
                `OFS_COUNT + 6'h01: count_value_r[15:8] <= wdata;
                `OFS_PER: per_r[7:0] <= wdata;
                `OFS_PER + 6'h01: per_r[15:8] <= wdata;
                `OFS_PERBUF: begin
                    perbuf_r[7:0] <= wdata;
                    bv_r[0] <= ~split; // [RULE17]
                end
                `OFS_PERBUF + 6'h01: begin
                    perbuf_r[15:8] <= wdata;
                    bv_r[0] <= ~split;
                end
                default: begin
                    for (j = 0; j < NCH; j = j + 1) begin
                        if (addr == `OFS_CV0 + 2 * j)
                            compare_value_r[j][7:0] <= wdata;
                        if (addr == `OFS_CV0 + 2 * j + 1)
                            compare_value_r[j][15:8] <= wdata;
                        if (addr == `OFS_CVBUF0 + 2 * j) begin
                            compare_buffer_r[j][7:0] <= wdata;
                            bv_r[j+1] <= ~split;
                        end
                        if (addr == `OFS_CVBUF0 + 2 * j + 1) begin
                            compare_buffer_r[j][15:8] <= wdata;
                            bv_r[j+1] <= ~split;
                        end
                    end
                end
            endcase
        end
        // flags: write one clears, but a new event in the same cycle wins
        if (wr_stb & (addr == `OFS_FLAGS)) begin
            interrupt_flag_reg_r <= interrupt_flag_reg_r & ~wdata;
        end
        if (wrap_cond) interrupt_flag_reg_r[`FLG_WRAP] <= 1'b1;
        if (hiuf_cond) interrupt_flag_reg_r[`FLG_HIUF] <= 1'b1; // [RULE18]
        for (j = 0; j < NCH; j = j + 1) begin
            if (step & lo_match[j]) interrupt_flag_reg_r[`FLG_CV0+j] <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// events, pins and read data
always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        overflow_event_r <= 1'b0;
        high_byte_underflow_r <= 1'b0;
        compare_event_r <= {NCH{1'b0}};
        pin_override_r <= {(2*NCH){1'b0}};
        waveform_out_n_r <= {(2*NCH){1'b0}};
        rdata_r <= 8'h00;
    end else begin
        // same conditions as the flags, one clock wide each
        overflow_event_r <= wrap_cond; // [RULE21] [RULE23]
        high_byte_underflow_r <= hiuf_cond; // [RULE22] [RULE23]
        compare_event_r <= step ? lo_match : {NCH{1'b0}}; // [RULE21] [RULE23]
        for (m = 0; m < NCH; m = m + 1) begin
            pin_override_r[m] <= split ? control_b_reg_r[m] :
                (control_b_reg_r[`CTLB_CHEN0+m] &
                 (waveform_mode_select != `WG_NORMAL)); // [RULE10]
            pin_override_r[NCH+m] <= split & control_b_reg_r[`CTLB_CHEN0+m];
            waveform_out_n_r[m] <= lo_level[m] ^ pin_invert[m]; // [RULE10]
            waveform_out_n_r[NCH+m] <= hi_level[m] ^ pin_invert[NCH+m];
        end
        rdata_r <= rd_stb ? rd_nxt : 8'h00;
    end
end

always @* begin
    rd_nxt = 8'h00;
    case (addr)
        `OFS_CTLA: rd_nxt = {4'h0, prescale_select_r, en_r};
        `OFS_CTLB: rd_nxt = control_b_reg_r;
        `OFS_CTRLC: rd_nxt = ctrlc_r;
        `OFS_CTLD: rd_nxt = {7'h00, dual_8bit_enable_r};
        `OFS_CTRLECLR, `OFS_CTLESET: rd_nxt = {6'h00, lock_update_r, dir_r};
        `OFS_CTRLFCLR, `OFS_CTRLFSET: rd_nxt[NCH:0] = bv_r;
        `OFS_FLAGS: rd_nxt = interrupt_flag_reg_r;
        `OFS_COUNT: rd_nxt = count_value_r[7:0];
        `OFS_COUNT + 6'h01: rd_nxt = count_value_r[15:8];
        `OFS_PER: rd_nxt = per_r[7:0];
        `OFS_PER + 6'h01: rd_nxt = per_r[15:8];
        `OFS_PERBUF: rd_nxt = perbuf_r[7:0];
        `OFS_PERBUF + 6'h01: rd_nxt = perbuf_r[15:8];
        default: begin
            for (n = 0; n < NCH; n = n + 1) begin
                if (addr == `OFS_CV0 + 2 * n) rd_nxt = compare_value_r[n][7:0];
                if (addr == `OFS_CV0 + 2 * n + 1) rd_nxt = compare_value_r[n][15:8];
                if (addr == `OFS_CVBUF0 + 2 * n) rd_nxt = compare_buffer_r[n][7:0];
                if (addr == `OFS_CVBUF0 + 2 * n + 1) rd_nxt = compare_buffer_r[n][15:8];
            end
        end
    endcase
end

endmodule

/* File: verif/timer_waveform_split_mode_chk.sv */
`timescale 1ns/10ps
module timer_waveform_split_mode_chk #(
    parameter AW = 6,
    parameter NCH = 3
) (
    input wire core_clk,
    input wire nrst,
    input wire [AW-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] rdata_r,
    input wire [2*NCH-1:0] pin_invert,
    input wire [2*NCH-1:0] pin_override_r,
    input wire [2*NCH-1:0] waveform_out_n_r,
    input wire overflow_event_r,
    input wire high_byte_underflow_r,
    input wire [NCH-1:0] compare_event_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // shadow of the control bits that the outputs hang on
    reg en_r;
    reg split_r;
    reg [2:0] wg_r;
    reg [2:0] cmpen_r;
    wire cmd_rst = wr_stb && addr == 6'h05 && wdata[3:2] == 2'h3 && !en_r;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            en_r <= 1'b0;
            split_r <= 1'b0;
            wg_r <= 3'h0;
            cmpen_r <= 3'h0;
        end else if (cmd_rst) begin
            split_r <= 1'b0;
            wg_r <= 3'h0;
            cmpen_r <= 3'h0;
        end else if (wr_stb) begin
            if (addr == 6'h00)
                en_r <= wdata[0];
            if (addr == 6'h01)
                wg_r <= wdata[2:0];
            if (addr == 6'h01)
                cmpen_r <= wdata[6:4];
            if (addr == 6'h03)
                split_r <= wdata[0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence restart_s;
        wr_stb && addr == 6'h05 && wdata[3:2] == 2'h2;
    endsequence
    sequence hard_reset_s;
        cmd_rst;
    endsequence
    // outputs lag the tick by one register, so two idle samples are enough; three are checked
    sequence idle3_s;
        !en_r && !$past(en_r) && !$past(en_r, 2);
    endsequence
    rd_zero_a: assert property (!$past(rd_stb) |-> rdata_r == 8'h00)
        else $error("read data outside its slot");
    rd_unmap_a: assert property (rd_stb && addr == 6'h0C |=> rdata_r == 8'h00)
        else $error("unmapped read not zero");
    override_a: assert property ($past(!split_r) |->
        pin_override_r[2:0] == $past(wg_r != 3'h0 ? cmpen_r : 3'h0))
        else $error("pin override wrong");
    hiuf_split_a: assert property (high_byte_underflow_r |->
        split_r || $past(split_r) || $past(split_r, 2))
        else $error("high underflow outside split");
    wrap_quiet_a: assert property (idle3_s |->
        !overflow_event_r && !high_byte_underflow_r)
        else $error("underflow or overflow while stopped");
    cmp_quiet_a: assert property (idle3_s |->
        compare_event_r == {NCH{1'b0}})
        else $error("compare event while stopped");
    restart_lvl_a: assert property (restart_s |->
        ##2 waveform_out_n_r[2:0] == $past(pin_invert[2:0]))
        else $error("restart left a level set");
    reset_lvl_a: assert property (hard_reset_s |->
        ##2 waveform_out_n_r == $past(pin_invert))
        else $error("reset command left a level set");
endmodule

/* File: verif/port_pin_model.sv */
`timescale 1ns/10ps
module port_pin_model (
    input wire core_clk,
    input wire nrst,
    input wire [5:0] port_out,
    input wire [5:0] pin_override_r,
    input wire [5:0] waveform_out_n_r,
    input wire [2:0] compare_event_r,
    output wire [5:0] pin_level,
    output reg [15:0] ev0_hits
);
    // timer level wins over the port latch per pin
    assign pin_level = (pin_override_r & waveform_out_n_r) | (~pin_override_r & port_out);
    ////////////////////////////////////////////////////////////////////////////
    // event user side: each high cycle is one event
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            ev0_hits <= 16'h0000;
        else if (compare_event_r[0])
            ev0_hits <= ev0_hits + 16'h0001;
    end
endmodule

/* File: verif/tb_timer_waveform_split_mode.sv */
`timescale 1ns/10ps
module tb_timer_waveform_split_mode;
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    reg [5:0] addr = 6'h00;
    reg [7:0] wdata = 8'h00;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    reg [5:0] pin_invert = 6'h00;
    wire [7:0] rdata_r;
    wire [5:0] pin_override_r;
    wire [5:0] waveform_out_n_r;
    wire [5:0] pin_level;
    wire overflow_event_r;
    wire high_byte_underflow_r;
    wire [2:0] compare_event_r;
    wire [15:0] ev0_hits;
    integer failures = 0;
    integer compares = 0;
    integer i;
    integer c;
    reg [15:0] k;
    reg [31:0] seed = 32'h5805;
    reg [7:0] exp_q[$];
    reg pend = 1'b0;
    always #5 core_clk = ~core_clk;
    timer_waveform_split_mode dut_u (.core_clk(core_clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata_r),
        .pin_invert(pin_invert), .pin_override_r(pin_override_r),
        .waveform_out_n_r(waveform_out_n_r), .overflow_event_r(overflow_event_r),
        .high_byte_underflow_r(high_byte_underflow_r), .compare_event_r(compare_event_r));
    port_pin_model pins_u (.core_clk(core_clk), .nrst(nrst), .port_out(6'h15),
        .pin_override_r(pin_override_r), .waveform_out_n_r(waveform_out_n_r),
        .compare_event_r(compare_event_r), .pin_level(pin_level), .ev0_hits(ev0_hits));
    ////////////////////////////////////////////////////////////////////////////
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task end_sim;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk_val(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (pend) begin
            compares = compares + 1;
            if (exp_q.size() == 0 || rdata_r !== exp_q[0]) begin
                failures = failures + 1;
                $display("BAD %0t read data %h", $time, rdata_r);
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
        pend = rd_stb;
    end
    task wr(input [5:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            addr <= a;
            wdata <= d;
            wr_stb <= 1'b1;
            @(posedge core_clk);
            wr_stb <= 1'b0;
        end
    endtask
    task rd(input [5:0] a, input [7:0] e);
        begin
            @(posedge core_clk);
            addr <= a;
            rd_stb <= 1'b1;
            exp_q.push_back(e);
            @(posedge core_clk);
            rd_stb <= 1'b0;
        end
    endtask
    // list of address/data pairs, first pair in the top bits, zero pairs skipped
    task wl(input [127:0] v);
        integer j;
        begin
            for (j = 7; j >= 0; j = j - 1) begin
                if (v[j*16 +: 16] != 16'h0000)
                    wr(v[j*16+8 +: 6], v[j*16 +: 8]);
            end
        end
    endtask
    // cycles between two pulses of one event line
    task gap(input integer sel, input integer exp);
        integer n;
        integer t;
        integer p;
        reg [2:0] ev;
        begin
            n = 0;
            t = 0;
            p = 0;
            while (p < 2 && t < 3000) begin
                @(posedge core_clk);
                ev = {compare_event_r[0], high_byte_underflow_r, overflow_event_r};
                t = t + 1;
                n = n + (p == 1 ? 1 : 0);
                if (ev[sel] === 1'b1)
                    p = p + 1;
            end
            if (t >= 3000) begin
                failures = failures + 1;
                $display("BAD %0t event missing", $time);
                end_sim;
            end else
                chk_val(n[15:0], exp[15:0]);
        end
    endtask
    task hi(input integer b, input integer cyc, input [15:0] exp);
        integer j;
        reg [15:0] h;
        begin
            h = 16'h0000;
            for (j = 0; j < cyc; j = j + 1) begin
                @(posedge core_clk);
                if (pin_level[b] === 1'b1)
                    h = h + 16'h0001;
            end
            chk_val(h, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        rd(6'h27, 8'hFF);
        rd(6'h0C, 8'h00);
        seed = xs(seed);
        wr(6'h2A, seed[7:0]);
        rd(6'h2A, seed[7:0]);
        pin_invert <= seed[13:8];
        wr(6'h01, 8'h70);
        repeat (2) @(posedge core_clk);
        chk_val({10'h000, pin_override_r}, 16'h0000);
        $display("registers done");
        for (i = 0; i < 2; i = i + 1) begin
            c = i * 2;
            wl({16'h0508, 8'h28, c[7:0], 16'h0171, 16'h0001});
            repeat (2) @(posedge core_clk);
            chk_val({13'h0000, pin_override_r[2:0]}, 16'h0007);
            gap(2, c + 1);
            hi(0, 8 * (c + 1), c[15:0] * 16'h0004 + 16'h0004);
            wr(6'h00, 8'h00);
        end
        $display("frequency done");
        // up counting only, top to zero is not a legal sawtooth setup
        wl({16'h0508, 16'h2602, 16'h2700, 16'h2800, 16'h2A05, 16'h2B00, 16'h0173, 16'h0001});
        gap(0, 3);
        hi(0, 9, pin_invert[0] ? 16'h0009 : 16'h0000);
        hi(1, 9, pin_invert[1] ? 16'h0000 : 16'h0009);
        wr(6'h00, 8'h00);
        $display("sawtooth done");
        wl({16'h0508, 16'h2603, 16'h2A03, 16'h0175, 16'h0001});
        gap(0, 6);
        hi(0, 12, pin_invert[0] ? 16'h000C : 16'h0000);
        hi(1, 12, pin_invert[1] ? 16'h0000 : 16'h000C);
        wr(6'h00, 8'h00);
        $display("dual slope done");
        wl({16'h2055, 16'h0508});
        rd(6'h20, 8'h00);
        wl({16'h3607, 16'h0502});
        rd(6'h26, 8'h03);
        wr(6'h05, 8'h04);
        rd(6'h26, 8'h07);
        wl({16'h0001, 16'h050C});
        rd(6'h00, 8'h01);
        wr(6'h00, 8'h00);
        wr(6'h05, 8'h0C);
        rd(6'h26, 8'hFF);
        rd(6'h01, 8'h00);
        $display("commands done");
        wl({16'h0301, 16'h3611, 16'h2602, 16'h2704, 16'h28F0, 16'h2901, 16'h0001});
        rd(6'h06, 8'h00);
        k = ev0_hits;
        gap(0, 3);
        gap(1, 5);
        chk_val(ev0_hits, k);
        wr(6'h00, 8'h00);
        $display("split done");
        end_sim;
    end
endmodule

bind timer_waveform_split_mode timer_waveform_split_mode_chk #(.AW(AW), .NCH(NCH)) chk_u (
    .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_r(rdata_r), .pin_invert(pin_invert),
    .pin_override_r(pin_override_r), .waveform_out_n_r(waveform_out_n_r),
    .overflow_event_r(overflow_event_r), .high_byte_underflow_r(high_byte_underflow_r),
    .compare_event_r(compare_event_r));
